// ---- design/ptxc_top.sv ----
// Transmit and power-control half of one lane's MAC/PHY port.
// Assumes every input is synchronous to clk_in, the single port clock.
//
// Overview of operation
// [R1] With the hard subsystem, only transmit bits 31:0 are used.
// [R2] With a soft core, all 40 transmit bits are accepted; the symbol stream (tx_sym_out) carries only bits 31:0.
// [R3] Bytes of each word are serialized lowest byte first.
// [R4] Each kind flag marks its byte: 0 data, 1 control.
// [R5] With a soft core the kind flags are ignored.
// [R6] Request in P1 starts receiver detect; in P0 enters loopback.
// [R7] Compliance forces running disparity negative.
// [R8] Compliance plus electrical idle switches the lane off.
// [R9] Two-bit power-down selects P0, P0s, P1 or P2.
// [R10] P0s keeps interface clock running; receiver saves power.
// [R11] P1 keeps clock running; receiver and transmitter idle.
// [R12] P2 stops interface clock and minimizes power.
// [R13] Rate 00 selects Gen1, 01 selects Gen2.
// [R14] Three-bit margin selects normal, one, vendor or reduced level.
// [R15] Half-duplex reference clock must match recovered clock.
// [R16] All port signals are synchronous to one interface clock.
// [R17] MAC holds electrical idle in P0s and P1.
// [R18] Power-down codes 00 P0, 01 P0s, 10 P1, 11 P2.
`include "ptxc_map.svh"

module ptxc_top
  import ptxc_pkg::*;
#(
  parameter int DATA_W = `PTXC_DATA_W,
  parameter int BYTES  = `PTXC_BYTES
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  // Configuration
  input  wire logic                 hard_pcie_subsystem_in,
  // Transmit word
  input  wire logic [DATA_W-1:0]    tx_data_in,
  input  wire logic [BYTES-1:0]     lane_tx_char_kind_in,
  // Control
  input  wire ptxc_pkg::ptxc_ctrl_t ctrl_in,
  // Word towards the coder
  output logic      [DATA_W-1:0]    tx_word_out,
  output logic      [BYTES-1:0]     tx_kind_out,
  output logic      [7:0]           tx_sym_out,
  output logic                      tx_sym_kind_out,
  // Lane status
  output ptxc_pkg::ptxc_stat_t      stat_out
);

  import ptxc_pkg::*;

  // ---------------------------------------------------------------
  // Word path
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] word_nxt;
  logic [BYTES-1:0]  kind_nxt;
  logic [$clog2(BYTES)-1:0] sym_idx;
  logic              load;

  always_comb begin
    word_nxt = tx_data_in;                                   // [R2]
    kind_nxt = '0;                                           // [R5]
    if (hard_pcie_subsystem_in) begin
      word_nxt = {{(DATA_W-`PTXC_HARD_DATA_W){1'b0}},
                  tx_data_in[`PTXC_HARD_DATA_W-1:0]};        // [R1]
      kind_nxt = lane_tx_char_kind_in;                       // [R4]
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      tx_word_out <= '0;
      tx_kind_out <= '0;
    end else begin
      tx_word_out <= word_nxt;   // [R16]
      tx_kind_out <= kind_nxt;
    end
  end

  // Symbol stream: one word loaded every BYTES cycles
  logic [$clog2(BYTES)-1:0] phase_r;

  always_ff @(posedge clk_in) begin
    if (!resetn_in)
      phase_r <= '0;
    else
      phase_r <= phase_r + 1'b1;
  end

  assign load = (phase_r == '0);

  ptxc_serializer #(.BYTES(BYTES)) u_ser (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .load_in     (load),
    .word_in     (word_nxt[BYTES*8-1:0]),
    .kind_in     (kind_nxt),
    .sym_out     (tx_sym_out),
    .sym_kind_out(tx_sym_kind_out),
    .idx_out     (sym_idx)
  );

  // ---------------------------------------------------------------
  // Power, detect and level control
  // ---------------------------------------------------------------
  ptxc_pstate_t pstate;
  ptxc_stat_t   stat_nxt;

  assign pstate = ptxc_pstate_t'(ctrl_in.power_down);        // [R9] [R18]

  always_comb begin
    stat_nxt = '0;
    stat_nxt.clk_run = (pstate != PTXC_P2);                  // [R12]
    case (pstate)
      PTXC_P0: begin
        stat_nxt.loopback = ctrl_in.detect_or_loopback;      // [R6]
      end
      PTXC_P0S: begin
        stat_nxt.rx_idle = 1'b1;                             // [R10]
        stat_nxt.tx_idle = 1'b1;                             // [R17]
      end
      PTXC_P1: begin
        stat_nxt.rx_idle   = 1'b1;                           // [R11]
        stat_nxt.tx_idle   = 1'b1;
        stat_nxt.rx_detect = ctrl_in.detect_or_loopback;     // [R6]
      end
      default: begin
        stat_nxt.rx_idle = 1'b1;                             // [R12]
        stat_nxt.tx_idle = 1'b1;
      end
    endcase
    if (ctrl_in.elec_idle)
      stat_nxt.tx_idle = 1'b1;
    stat_nxt.force_neg_disp = ctrl_in.compliance;            // [R7]
    stat_nxt.lane_off = ctrl_in.compliance && ctrl_in.elec_idle; // [R8]
    stat_nxt.gen2 = (ctrl_in.rate == `PTXC_RATE_GEN2);       // [R13]
    if (ctrl_in.margin == `PTXC_MARGIN_NORMAL)               // [R14]
      stat_nxt.margin_class = PTXC_MARGIN_NORM;
    else if (ctrl_in.margin == `PTXC_MARGIN_ONE)
      stat_nxt.margin_class = PTXC_MARGIN_M1;
    else if (ctrl_in.margin < `PTXC_MARGIN_RED)
      stat_nxt.margin_class = PTXC_MARGIN_VENDOR;
    else
      stat_nxt.margin_class = PTXC_MARGIN_LOW;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in)
      stat_out <= '0;
    else
      stat_out <= stat_nxt;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_hard_upper_zero: assert property (                           // [R1]
    hard_pcie_subsystem_in |=> tx_word_out[DATA_W-1:32] == '0)
    else $error("Upper transmit byte passed with hard subsystem");

  a_soft_full_word: assert property (                            // [R2]
    !hard_pcie_subsystem_in |=> tx_word_out == $past(tx_data_in))
    else $error("Soft core word not passed whole");

  sequence s_load;
    load ##1 1'b1;
  endsequence
  a_byte_order: assert property (                                // [R3]
    load ##1 resetn_in |=> tx_sym_out == $past(word_nxt[7:0], 2))
    else $error("First symbol is not the lowest byte");

  a_sym_index: assert property (                                 // [R3]
    s_load |=> sym_idx == '0)
    else $error("Symbol index not reset on load");

  a_kind_pass: assert property (                                 // [R4]
    hard_pcie_subsystem_in |=> tx_kind_out == $past(lane_tx_char_kind_in))
    else $error("Kind flags not passed");

  a_soft_kind_zero: assert property (                            // [R5]
    !hard_pcie_subsystem_in |=> tx_kind_out == '0)
    else $error("Kind flags used with soft core");

  a_detect_p1: assert property (                                 // [R6]
    (pstate == PTXC_P1 && ctrl_in.detect_or_loopback)
      |=> stat_out.rx_detect && !stat_out.loopback)
    else $error("Receiver detect not started in P1");

  a_loop_p0: assert property (                                   // [R6]
    (pstate == PTXC_P0 && ctrl_in.detect_or_loopback)
      |=> stat_out.loopback && !stat_out.rx_detect)
    else $error("Loopback not entered in P0");

  a_comp_disp: assert property (                                 // [R7]
    ctrl_in.compliance |=> stat_out.force_neg_disp)
    else $error("Disparity not forced negative");

  a_lane_off: assert property (                                  // [R8]
    (ctrl_in.compliance && ctrl_in.elec_idle) |=> stat_out.lane_off)
    else $error("Lane not switched off");

  a_p1_idle: assert property (                                   // [R11]
    pstate == PTXC_P1 |=> stat_out.clk_run && stat_out.tx_idle
                          && stat_out.rx_idle)
    else $error("P1 state outputs wrong");

  a_p0s_clk: assert property (                                   // [R10]
    pstate == PTXC_P0S |=> stat_out.clk_run && stat_out.rx_idle)
    else $error("P0s state outputs wrong");

  a_p2_clk_off: assert property (                                // [R12]
    pstate == PTXC_P2 |=> !stat_out.clk_run)
    else $error("Clock not stopped in P2");

  a_rate_gen2: assert property (                                 // [R13]
    ctrl_in.rate == `PTXC_RATE_GEN1 |=> !stat_out.gen2)
    else $error("Gen1 code gave Gen2");

  a_margin_low: assert property (                                // [R14]
    ctrl_in.margin[2] |=> stat_out.margin_class == PTXC_MARGIN_LOW)
    else $error("Reduced margin not selected");

endmodule

// ---- design/ptxc_map.svh ----
// Constants for the transmit/power-control side of the lane interface.
// Assumes inclusion by ptxc_pkg and the design modules only.
`ifndef PTXC_MAP_SVH
`define PTXC_MAP_SVH

`define PTXC_DATA_W        40
`define PTXC_HARD_DATA_W   32
`define PTXC_BYTES         4
`define PTXC_PD_P0         2'h0
`define PTXC_PD_P0S        2'h1
`define PTXC_PD_P1         2'h2
`define PTXC_PD_P2         2'h3
`define PTXC_RATE_GEN1     2'h0
`define PTXC_RATE_GEN2     2'h1
`define PTXC_MARGIN_NORMAL 3'h0
`define PTXC_MARGIN_ONE    3'h1
`define PTXC_MARGIN_RED    3'h4

`endif

// ---- design/ptxc_pkg.sv ----
// Types for the transmit/power-control side of the lane interface.
// Assumes ptxc_map.svh is on the include path.
`include "ptxc_map.svh"

package ptxc_pkg;

  typedef enum logic [1:0] {
    PTXC_P0, PTXC_P0S, PTXC_P1, PTXC_P2
  } ptxc_pstate_t;

  typedef enum logic [1:0] {
    PTXC_MARGIN_NORM, PTXC_MARGIN_M1, PTXC_MARGIN_VENDOR, PTXC_MARGIN_LOW
  } ptxc_mclass_t;

  // Control request from the MAC
  typedef struct packed {
    logic [1:0] power_down;
    logic [1:0] rate;
    logic [2:0] margin;
    logic       compliance;
    logic       elec_idle;
    logic       detect_or_loopback;
  } ptxc_ctrl_t;

  // Lane status registered out of ptxc_top; the serializer does not use it
  typedef struct packed {
    logic         clk_run;
    logic         rx_idle;
    logic         tx_idle;
    logic         lane_off;
    logic         force_neg_disp;
    logic         rx_detect;
    logic         loopback;
    logic         gen2;
    ptxc_mclass_t margin_class;
  } ptxc_stat_t;

endpackage

// ---- design/ptxc_serializer.sv ----
// Byte serializer: shifts one parallel word out a symbol at a time.
// Assumes word_in is valid in each cycle that load_in is high; it is ignored otherwise.
`include "ptxc_map.svh"

module ptxc_serializer #(
  parameter int BYTES = `PTXC_BYTES
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  // Word side
  input  wire logic                 load_in,
  input  wire logic [BYTES*8-1:0]   word_in,
  input  wire logic [BYTES-1:0]     kind_in,
  // Symbol side
  output logic      [7:0]           sym_out,
  output logic                      sym_kind_out,
  output logic      [$clog2(BYTES)-1:0] idx_out
);

  logic [BYTES*8-1:0] word_r;
  logic [BYTES-1:0]   kind_r;
  logic [$clog2(BYTES)-1:0] idx_r;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      word_r <= '0;
      kind_r <= '0;
      idx_r  <= '0;
    end else if (load_in) begin
      word_r <= word_in;
      kind_r <= kind_in;
      idx_r  <= '0;
    end else begin
      word_r <= word_r >> 8;
      kind_r <= kind_r >> 1;
      idx_r  <= idx_r + 1'b1;
    end
  end

  // Lowest byte leaves first
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sym_out      <= 8'h00;
      sym_kind_out <= 1'b0;
      idx_out      <= '0;
    end else begin
      sym_out      <= word_r[7:0];   // [R3]
      sym_kind_out <= kind_r[0];
      idx_out      <= idx_r;
    end
  end

endmodule

// ---- test/ptxc_mac_model.sv ----
// MAC-side model: turns the bench's requests into the control struct.
// Assumes its inputs change only just after a rising edge of clk_in.
module ptxc_mac_model
  import ptxc_pkg::*;
(
  // Requests from the bench
  input  wire logic [1:0]           pd_in,
  input  wire logic [1:0]           rate_in,
  input  wire logic [2:0]           margin_in,
  input  wire logic                 comp_in,
  input  wire logic                 ei_in,
  input  wire logic                 req_in,
  // Towards the lane
  output ptxc_pkg::ptxc_ctrl_t      ctrl_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Control assembly
  // ----------------------------------------------------------------
  // All fields follow the bench, which moves on clk_in only
  always_comb begin
    ctrl_out.power_down         = pd_in;
    ctrl_out.rate               = rate_in;
    ctrl_out.margin             = margin_in;
    ctrl_out.compliance         = comp_in;
    ctrl_out.detect_or_loopback = req_in;
    // A real MAC may not leave the transmitter live in these states
    ctrl_out.elec_idle = ei_in | (pd_in == 2'h1) | (pd_in == 2'h2);
  end
endmodule

// ---- test/pipe_tx_control_interface_tb_top.sv ----
// Self-checking bench for the lane transmit/power-control block.
// Assumes the design package is compiled first.
module pipe_tx_control_interface_tb_top
  import ptxc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic             clk_in = 1'b0;
  logic             resetn_in = 1'b0;
  logic             hard = 1'b1;
  logic [39:0]      data = '0;
  logic [3:0]       kind = '0;
  logic [1:0]       pd = '0;
  logic [1:0]       rate = '0;
  logic [2:0]       margin = '0;
  logic             comp = 1'b0;
  logic             ei = 1'b0;
  logic             req = 1'b0;
  ptxc_ctrl_t       ctrl;
  logic [39:0]      word;
  logic [3:0]       kout;
  logic [7:0]       sym;
  logic             symk;
  ptxc_stat_t       stat;
  int               failures = 0;
  int               compares = 0;
  int unsigned      cyc = 0;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  ptxc_mac_model u_ptxc_mac_model (.pd_in(pd), .rate_in(rate),
    .margin_in(margin), .comp_in(comp), .ei_in(ei), .req_in(req),
    .ctrl_out(ctrl));
  ptxc_top u_ptxc_top (.clk_in(clk_in), .resetn_in(resetn_in),
    .hard_pcie_subsystem_in(hard), .tx_data_in(data),
    .lane_tx_char_kind_in(kind), .ctrl_in(ctrl), .tx_word_out(word),
    .tx_kind_out(kout), .tx_sym_out(sym), .tx_sym_kind_out(symk),
    .stat_out(stat));

  // One steady clock stands in for the lane reference clock
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  // Edges since reset release; fixes which byte the serializer shows
  always @(posedge clk_in) begin
    if (!resetn_in)
      cyc <= 0;
    else
      cyc <= cyc + 1;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge clk_in);
    #2;
  endtask

  task automatic chk(input string nm, input logic [39:0] e,
                     input logic [39:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic ptxc_stat_t exp_stat();
    logic       e;
    ptxc_stat_t s;
    e = ei | (pd == 2'h1) | (pd == 2'h2);
    s.clk_run        = pd != 2'h3;
    s.rx_idle        = pd != 2'h0;
    s.tx_idle        = (pd != 2'h0) | e;
    s.lane_off       = comp & e;
    s.force_neg_disp = comp;
    s.rx_detect      = (pd == 2'h2) & req;
    s.loopback       = (pd == 2'h0) & req;
    s.gen2           = rate == 2'h1;
    s.margin_class   = margin == 3'h0 ? PTXC_MARGIN_NORM :
                       margin == 3'h1 ? PTXC_MARGIN_M1 :
                       margin[2] ? PTXC_MARGIN_LOW : PTXC_MARGIN_VENDOR;
    return s;
  endfunction

  task automatic chk_stat(input string nm);
    chk(nm, 40'(exp_stat()), 40'(stat));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_word();
    data = 40'ha5_8765_4321;
    kind = 4'h9;
    hard = 1'b1;
    step();
    chk("word_hard", 40'h00_8765_4321, word);
    chk("kind_hard", 40'h9, 40'(kout));
    hard = 1'b0;
    step();
    chk("word_soft", 40'ha5_8765_4321, word);
    chk("kind_soft", 40'h0, 40'(kout));
  endtask

  task automatic t_serial();
    int unsigned b;
    hard = 1'b1;
    data = 40'hff_1312_1110;
    kind = 4'h5;
    repeat (8) step();
    // Words load every fourth edge from release; byte 0 shows one edge later
    for (int i = 0; i < 6; i++) begin
      b = (cyc - 2) % 4;
      chk("sym", 40'(8'h10 + b), 40'(sym));
      chk("sym_kind", 40'(kind[b]), 40'(symk));
      step();
    end
  endtask

  task automatic t_power();
    for (int s = 0; s < 8; s++) begin
      pd  = s[1:0];
      req = s[2];
      step();
      chk_stat("stat_power");
    end
    req = 1'b0;
    pd  = 2'h0;
  endtask

  task automatic t_compl();
    for (int s = 0; s < 4; s++) begin
      comp = s[0];
      ei   = s[1];
      step();
      chk_stat("stat_compliance");
    end
    comp = 1'b0;
    ei   = 1'b0;
  endtask

  task automatic t_rate_margin();
    for (int s = 0; s < 8; s++) begin
      margin = s[2:0];
      rate   = {1'b0, s[0]};
      step();
      chk_stat("stat_rate_margin");
    end
  endtask

  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) step();
    resetn_in = 1'b1;
    step();
    t_word();
    t_serial();
    t_power();
    t_compl();
    t_rate_margin();
    close_out();
  end

  initial begin
    #(2000 * 25);
    failures++;
    close_out();
  end
endmodule
